// ---- hdl/gio_pkg.sv ----
package gio_pkg;
  // data-space locations served inside the block
  localparam logic [15:0] SIZE_REG_ADDR = 16'h0005;
  localparam logic [15:0] IOWAIT_ADDR   = 16'h0028;
  // data-space port hole: ports 50h..5Fh
  localparam logic [11:0] PORTHOLE_TAG  = 12'h005;
  // reset values and fill bits
  localparam logic [7:0]  SIZE_REG_RST  = 8'h00;
  localparam logic [15:0] IOWAIT_RST    = 16'h0000;
  localparam logic [7:0]  SIZE_HI_READ  = 8'hFF;
  // port bits that pick a wait field in each mapping
  localparam int          PAIR_LSB      = 1;
  localparam int          BLOCK_LSB     = 13;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b100
  } cyc_state_t;

  // two-bit wait field number idx of the I/O wait register
  function automatic logic [1:0] wait_field(input logic [15:0] v, input logic [2:0] idx);
    wait_field = v[{idx, 1'b0} +: 2];
  endfunction : wait_field

  // window at top of data space, leading ones of the size value
  function automatic logic is_global(input logic [7:0] size, input logic [15:0] a);
    is_global = size[7] && ((a[15:8] & size) == size);
  endfunction : is_global

  function automatic logic in_porthole(input logic [15:0] a);
    in_porthole = (a[15:4] == PORTHOLE_TAG);
  endfunction : in_porthole
endpackage : gio_pkg

// ---- hdl/wait_sel_if.sv ----
`timescale 1ns/100ps
interface wait_sel_if;
  logic [15:0] io_port_wait_fields;
  logic        wide_block_wait_map;
  logic [15:0] port;
  logic [1:0]  waits;
  modport ctrl (output io_port_wait_fields, output wide_block_wait_map, output port, input waits);
  modport sel  (input io_port_wait_fields, input wide_block_wait_map, input port, output waits);
endinterface : wait_sel_if

// ---- hdl/wait_field_select.sv ----
`timescale 1ns/100ps
module wait_field_select
  import gio_pkg::*;
(
  wait_sel_if.sel bus
);
  logic [2:0] idx;

  // narrow map folds every port onto 0..15 by modulo sixteen, in pairs
  always_comb begin
    if (bus.wide_block_wait_map) begin
      idx = bus.port[BLOCK_LSB +: 3]; // [R14]
    end else begin
      idx = bus.port[PAIR_LSB +: 3]; // [R13]
    end
    bus.waits = wait_field(bus.io_port_wait_fields, idx);
  end
endmodule : wait_field_select

// ---- hdl/global_and_io_space_decode.sv ----
// Functional notes
// R01: eight-bit global region size register lives at data location 5h, low byte.
// R02: reading data location 5 returns ones in the upper byte.
// R03: size value selects a window at the top of data space, 000000XX none.
// R04: software loads only leading-ones size patterns; others fragment the map.
// R05: global data address drives global request low together with data select.
// R06: outside logic arbitrates and asserts READY once this device owns memory.
// R07: a global cycle is stretched until READY is seen.
// R08: global addresses get the wait states of the overlapped local range.
// R09: strobe, data select and other controls behave alike for local and global.
// R10: I/O accesses share address and data buses and drive I/O select low.
// R11: ports 50h..5Fh reachable through ordinary data reads and writes too.
// R12: data-mapped port access asserts I/O select and keeps data select high.
// R13: narrow map: field pairs serve ports 0..15, higher ports fold modulo sixteen.
// R14: wide map: each field governs one of eight 8K-port blocks.
// R15: address is global when size bit 7 set and masked address bits all ones.
`timescale 1ns/100ps
module global_and_io_space_decode
  import gio_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic        req_io,
  input  wire logic        req_write,
  input  wire logic [15:0] req_addr,
  input  wire logic [15:0] req_wdata,
  output logic             ack,
  output logic [15:0]      ack_rdata,
  input  wire logic [1:0]  data_wait_states,
  input  wire logic        wide_block_wait_map,
  output logic [7:0]       global_region_size,
  output logic [15:0]      ext_addr,
  output logic [15:0]      ext_data_out,
  output logic             ext_data_oe,
  input  wire logic [15:0] ext_data_in,
  input  wire logic        ready_pin,
  output logic             access_strobe_n,
  output logic             data_space_select_n,
  output logic             io_space_select_n,
  output logic             global_access_request_n,
  output logic             read_n,
  output logic             write_n
);
  typedef struct packed {
    cyc_state_t  st;
    logic [7:0]  gsize;
    logic [15:0] iowait;
    logic [1:0]  cnt;
    logic        rdy1;
    logic        rdy2;
    logic [15:0] din1;
    logic [15:0] din2;
    logic [15:0] addr;
    logic [15:0] dout;
    logic [15:0] rdata;
    logic        wr;
    logic        doe;
    logic        stb_n;
    logic        dsel_n;
    logic        isel_n;
    logic        greq_n;
    logic        rd_n;
    logic        we_n;
  } state_t;

  state_t r_q;
  state_t r_d;
  logic   take;
  logic   io_cyc;
  logic   glob;

  wait_sel_if wsel ();

  assign wsel.io_port_wait_fields = r_q.iowait;
  assign wsel.wide_block_wait_map = wide_block_wait_map;
  assign wsel.port                = req_addr;

  wait_field_select u_wsel (
    .bus (wsel.sel)
  );

  // one request at a time; the cycle owns the bus until it retires
  assign req_ready = (r_q.st == ST_IDLE);
  assign take      = req_valid && req_ready;
  assign io_cyc    = req_io || in_porthole(req_addr); // [R10] [R11]
  assign glob      = !io_cyc && is_global(r_q.gsize, req_addr); // [R03] [R15]

  // next-state of the whole block
  always_comb begin
    r_d      = r_q;
    r_d.rdy1 = ready_pin;
    r_d.rdy2 = r_q.rdy1;
    r_d.din1 = ext_data_in;
    r_d.din2 = r_q.din1;
    case (r_q.st)
      ST_IDLE: begin
        if (take) begin
          r_d.addr = req_addr;
          r_d.dout = req_wdata;
          r_d.wr   = req_write;
          if (!req_io && req_addr == SIZE_REG_ADDR) begin
            if (req_write) begin
              r_d.gsize = req_wdata[7:0]; // [R01]
            end
            r_d.rdata = {SIZE_HI_READ, r_q.gsize}; // [R02]
            r_d.st    = ST_DONE;
          end else if (!req_io && req_addr == IOWAIT_ADDR) begin
            if (req_write) begin
              r_d.iowait = req_wdata;
            end
            r_d.rdata = r_q.iowait;
            r_d.st    = ST_DONE;
          end else begin
            // same strobe timing for local and global data cycles
            r_d.st     = ST_WAIT;
            r_d.stb_n  = 1'b0; // [R09]
            r_d.rd_n   = req_write;
            r_d.we_n   = !req_write;
            r_d.doe    = req_write;
            r_d.isel_n = !io_cyc; // [R10] [R12]
            r_d.dsel_n = io_cyc; // [R12]
            r_d.greq_n = !glob; // [R05]
            // global data reuses the local generator's count for the same address
            r_d.cnt    = io_cyc ? wsel.waits : data_wait_states; // [R08] [R13] [R14]
          end
        end
      end
      ST_WAIT: begin
        if (r_q.cnt != 2'h0) begin
          r_d.cnt = r_q.cnt - 2'h1;
        end else if (r_q.rdy2) begin
          // only the synchronised READY may end the cycle
          r_d.st     = ST_DONE; // [R07] [R06]
          r_d.stb_n  = 1'b1;
          r_d.dsel_n = 1'b1;
          r_d.isel_n = 1'b1;
          r_d.greq_n = 1'b1;
          r_d.rd_n   = 1'b1;
          r_d.we_n   = 1'b1;
          r_d.doe    = 1'b0;
          if (!r_q.wr) begin
            r_d.rdata = r_q.din2;
          end
        end
      end
      ST_DONE: begin
        r_d.st = ST_IDLE;
      end
      default: begin
        r_d.st = ST_IDLE;
      end
    endcase
  end

  // reset values are constants only
  always_ff @(posedge clock) begin
    if (rst) begin
      r_q        <= '0;
      r_q.st     <= ST_IDLE;
      r_q.gsize  <= SIZE_REG_RST;
      r_q.iowait <= IOWAIT_RST;
      r_q.stb_n  <= 1'b1;
      r_q.dsel_n <= 1'b1;
      r_q.isel_n <= 1'b1;
      r_q.greq_n <= 1'b1;
      r_q.rd_n   <= 1'b1;
      r_q.we_n   <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // pin and answer outputs straight from flip-flops, except ack, which is decoded from the state register
  assign ack                     = (r_q.st == ST_DONE);
  assign ack_rdata               = r_q.rdata;
  assign global_region_size      = r_q.gsize;
  assign ext_addr                = r_q.addr;
  assign ext_data_out            = r_q.dout;
  assign ext_data_oe             = r_q.doe;
  assign access_strobe_n         = r_q.stb_n;
  assign data_space_select_n     = r_q.dsel_n;
  assign io_space_select_n       = r_q.isel_n;
  assign global_access_request_n = r_q.greq_n;
  assign read_n                  = r_q.rd_n;
  assign write_n                 = r_q.we_n;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  logic ext_data;
  assign ext_data = take && !io_cyc && req_addr != SIZE_REG_ADDR && req_addr != IOWAIT_ADDR;

  AST_SIZE_WRITE: assert property (take && !req_io && req_write && req_addr == SIZE_REG_ADDR // [R01]
    |=> global_region_size == $past(req_wdata[7:0]))
    else $error("size register not loaded");
  AST_SIZE_UPPER: assert property (take && !req_io && !req_write && req_addr == SIZE_REG_ADDR // [R02]
    |=> ack && ack_rdata == {SIZE_HI_READ, $past(global_region_size)})
    else $error("location 5 read wrong");
  AST_GLOBAL_REQ: assert property (ext_data && is_global(global_region_size, req_addr) // [R05]
    |=> !global_access_request_n && !data_space_select_n && io_space_select_n)
    else $error("global request missing");
  AST_LOCAL_DATA: assert property (ext_data && !is_global(global_region_size, req_addr) // [R09]
    |=> global_access_request_n && !data_space_select_n && !access_strobe_n)
    else $error("local data cycle wrong");
  AST_READY_HOLD: assert property (!access_strobe_n && !r_q.rdy2 // [R07]
    |=> !access_strobe_n && !ack)
    else $error("cycle ended without ready");
  AST_IO_SELECT: assert property (take && req_io // [R10]
    |=> !io_space_select_n && data_space_select_n && global_access_request_n)
    else $error("io select wrong");
  AST_PORTHOLE: assert property (take && !req_io && in_porthole(req_addr) // [R12]
    |=> !io_space_select_n && data_space_select_n && ext_addr == $past(req_addr))
    else $error("port hole access used data select");
  AST_WAIT_NARROW: assert property (take && io_cyc && !wide_block_wait_map // [R13]
    |=> r_q.cnt == wait_field(r_q.iowait, $past(req_addr[3:1])))
    else $error("narrow wait field wrong");
  AST_WAIT_WIDE: assert property (take && io_cyc && wide_block_wait_map // [R14]
    |=> r_q.cnt == wait_field(r_q.iowait, $past(req_addr[15:13])))
    else $error("wide wait field wrong");
  AST_GLOBAL_WAITS: assert property (ext_data && glob // [R08]
    |=> r_q.cnt == $past(data_wait_states))
    else $error("global waits differ from local");

  COV_GLOBAL: cover property (ext_data && glob ##[1:20] ack);
  COV_PORTHOLE: cover property (take && !req_io && in_porthole(req_addr) ##[1:20] ack);
  COV_STALL: cover property (!access_strobe_n && !r_q.rdy2 ##1 !access_strobe_n ##1 !access_strobe_n);
endmodule : global_and_io_space_decode

// ---- test/ext_bus_model.sv ----
`timescale 1ns/100ps
module ext_bus_model (
  input  wire logic        clock,
  input  wire logic        hold_ready,
  input  wire logic [3:0]  lag,
  input  wire logic        access_strobe_n,
  input  wire logic        read_n,
  input  wire logic [15:0] ext_addr,
  output logic             ready_pin,
  output logic [15:0]      ext_data_in
);
  logic [3:0]  cnt_q = 4'h0;
  logic [15:0] bus_q = 16'h5A5A;
  // arbitration delay counted from strobe; a released bus toggles so nothing stale matches
  always_ff @(posedge clock) begin
    cnt_q <= access_strobe_n ? 4'h0 : cnt_q + {3'h0, cnt_q != 4'hF};
    bus_q <= ~bus_q;
  end
  // grant only once memory is owned; hold_ready models an owner already granted
  assign ready_pin   = hold_ready || (!access_strobe_n && cnt_q >= lag);
  assign ext_data_in = read_n ? bus_q : ~ext_addr;
endmodule : ext_bus_model

// ---- test/global_and_io_space_decode_test.sv ----
`timescale 1ns/100ps
module global_and_io_space_decode_test;
  logic        clock = 0, rst = 1, req_valid = 0, req_io = 0, req_write = 0, wide = 0, hold = 1;
  logic [15:0] req_addr = 16'h0000, req_wdata = 16'h0000, ack_rdata, ext_addr, ext_data_out, ext_data_in;
  logic [1:0]  dws = 2'h0;
  logic [3:0]  lag = 4'h0;
  logic [7:0]  size;
  logic        req_ready, ack, oe, oe_seen, ready_pin, stb_n, dsel_n, isel_n, greq_n, rd_n, wr_n;
  logic [4:0]  pins;
  int          strobes, n_fail = 0, total_checks = 0;

  global_and_io_space_decode i_global_and_io_space_decode (.clock(clock), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req_io(req_io), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .ack(ack), .ack_rdata(ack_rdata), .data_wait_states(dws), .wide_block_wait_map(wide),
    .global_region_size(size), .ext_addr(ext_addr), .ext_data_out(ext_data_out), .ext_data_oe(oe),
    .ext_data_in(ext_data_in), .ready_pin(ready_pin), .access_strobe_n(stb_n), .data_space_select_n(dsel_n),
    .io_space_select_n(isel_n), .global_access_request_n(greq_n), .read_n(rd_n), .write_n(wr_n));
  ext_bus_model i_ext_bus_model (.clock(clock), .hold_ready(hold), .lag(lag), .access_strobe_n(stb_n),
    .read_n(rd_n), .ext_addr(ext_addr), .ready_pin(ready_pin), .ext_data_in(ext_data_in));

  // free-running clock
  initial forever #50 clock = ~clock;

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one request; pins latched at first strobe cycle, strobe length counted
  task automatic access(input logic io, input logic wr, input logic [15:0] a, input logic [15:0] d);
    @(posedge clock) #1;
    {req_valid, req_io, req_write, req_addr, req_wdata} = {1'b1, io, wr, a, d};
    @(posedge clock) #1;
    req_valid = 0;
    check("busy", req_ready, 16'h0000);
    strobes = 0;
    pins = 5'h1F;
    oe_seen = 1'b0;
    for (int i = 0; i < 60 && ack !== 1'b1; i++) begin
      if (stb_n === 1'b0) begin
        if (strobes == 0) begin
          pins = {dsel_n, isel_n, greq_n, wr_n, rd_n};
          oe_seen = oe;
        end
        strobes++;
      end
      @(posedge clock) #1;
    end
    check("ack", ack, 16'h0001);
  endtask : access

  task automatic t_size;
    check("rst size", size, 16'h0000);
    check("rst pins", {stb_n, dsel_n, isel_n, greq_n, wr_n, rd_n}, 16'h003F);
    access(0, 1, 16'h0005, 16'h12C0);
    check("size", size, 16'h00C0);
    access(0, 0, 16'h0005, 16'h0000);
    check("size read", ack_rdata, 16'hFFC0);
    $display("test size done");
  endtask : t_size

  task automatic t_global;
    logic [7:0]  sz [6] = '{8'h80, 8'h80, 8'hFF, 8'hFF, 8'hC0, 8'h03};
    logic [15:0] ad [6] = '{16'h8000, 16'h7FFF, 16'hFF00, 16'hFEFF, 16'hC000, 16'hFFFF};
    logic        gl [6] = '{1, 0, 1, 0, 1, 0};
    for (int k = 0; k < 6; k++) begin
      access(0, 1, 16'h0005, {8'h00, sz[k]});
      access(0, 0, ad[k], 16'h0000);
      check("global pins", pins, {2'b01, ~gl[k], 2'b10});
    end
    $display("test global done");
  endtask : t_global

  // slow arbiter: cycle must last until granted
  task automatic t_ready;
    {hold, lag} = {1'b0, 4'h6};
    access(0, 1, 16'h0005, 16'h0080);
    access(0, 0, 16'h8123, 16'h0000);
    check("stretch", strobes > 6, 16'h0001);
    check("global data", ack_rdata, ~16'h8123);
    access(1, 0, 16'hFFFE, 16'h0000);
    check("io pins", pins, 16'h0016);
    check("io data", ack_rdata, 16'h0001);
    access(0, 1, 16'h0051, 16'hBEEF);
    check("hole pins", pins, 16'h0015);
    check("hole addr", ext_addr, 16'h0051);
    check("hole data", ext_data_out, 16'hBEEF);
    check("hole drive", oe_seen, 16'h0001);
    check("drive off", oe, 16'h0000);
    hold = 1;
    $display("test ready done");
  endtask : t_ready

  task automatic t_waits;
    logic        wm [5] = '{0, 0, 0, 1, 1};
    logic        io [5] = '{1, 1, 0, 1, 1};
    logic [15:0] pt [5] = '{16'h0006, 16'h0016, 16'h0055, 16'h6000, 16'h2000};
    int          ex [5] = '{4, 4, 3, 4, 2};
    dws = 2'h2;
    access(0, 0, 16'h8123, 16'h0000);
    check("global waits", strobes, 16'h0003);
    access(0, 0, 16'h0123, 16'h0000);
    check("local waits", strobes, 16'h0003);
    check("local pins", pins, 16'h000E);
    dws = 2'h0;
    access(0, 1, 16'h0028, 16'hE4E4);
    access(0, 0, 16'h0028, 16'h0000);
    check("wait reg read", ack_rdata, 16'hE4E4);
    for (int k = 0; k < 5; k++) begin
      wide = wm[k];
      access(io[k], 0, pt[k], 16'h0000);
      check("io waits", strobes, ex[k]);
    end
    $display("test waits done");
  endtask : t_waits

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  // watchdog: whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clock);
    n_fail++;
    conclude();
  end

  initial begin
    repeat (2) @(posedge clock);
    #1 rst = 0;
    t_size();
    t_global();
    t_ready();
    t_waits();
    conclude();
  end
endmodule : global_and_io_space_decode_test
